// >>> hw/dwt_pkg.sv
// Shared constants and types for the debug wire trace and time-out block
package dwt_pkg;
  // Serial timing, in target clock cycles
  localparam int unsigned SYNC_CYC   = 128;  // Low longer than this is a sync request
  localparam int unsigned IDLE_CYC   = 512;  // Gap between falling edges before soft reset
  localparam int unsigned BIT1_CYC   = 10;   // Low of at most this many cycles reads as a one
  localparam int unsigned ACK_CYC    = 16;   // Length of the low acknowledge pulse
  localparam int unsigned CMD_BITS   = 8;    // Bits in one command byte
  localparam int unsigned RD_BITS    = 16;   // Bit slots the host spends collecting read data
  localparam int unsigned LOW_W      = 8;
  localparam int unsigned IDLE_W     = 10;

  // Command byte codes
  localparam logic [7:0] CMD_ENTER_DEBUG = 8'h90;
  localparam logic [7:0] CMD_STEP        = 8'h10;
  localparam logic [7:0] CMD_ACK_ENABLE  = 8'hd5;
  localparam logic [7:0] CMD_ACK_DISABLE = 8'hd6;
  localparam int unsigned CMD_READ_BIT   = 5;    // Set in every command that returns data

  // Reset values
  localparam logic RST_HANDSHAKE = 1'b0;
  localparam logic RST_ACTIVE    = 1'b0;

  typedef enum logic [1:0] {
    DWT_ST_IDLE   = 2'b00,
    DWT_ST_STEP   = 2'b01,
    DWT_ST_LOWPWR = 2'b10
  } dwt_step_t;
endpackage

// >>> hw/dwt_rx_if.sv
// Interface between the wire timer and the command core
`timescale 1ns/1ps
`default_nettype none
interface dwt_rx_if;
  logic bit_valid;
  logic bit_val;
  logic sync_done;
  logic timeout;
  logic arm;
  logic ignore;

  modport timer (output bit_valid, output bit_val, output sync_done, output timeout,
                 input arm, input ignore);
  modport core  (input bit_valid, input bit_val, input sync_done, input timeout,
                 output arm, output ignore);
endinterface
`default_nettype wire

// >>> hw/dwt_top.sv
// Debug wire command core with single-step tracing and serial time-out
//
// Operation
// R1 - A step with an interrupt pending only stacks the interrupt so the CPU resumes at the service routine.
// R2 - A step advances only the CPU while every other peripheral keeps running.
// R3 - The host must not step the soft breakpoint instruction, as the return address would land in debug code.
// R4 - A stepped stop or wait lets the CPU sleep and the step completes only when the CPU wakes.
// R5 - While the CPU sleeps after a stepped low-power instruction, all commands but enter-debug are served.
// R6 - Once system stop is reached no command is executed at all.
// R7 - When the CPU wakes from a stepped stop or wait, active debug mode is entered at the service routine.
// R8 - With handshake on, the step that traced a stop or wait gets no acknowledge, even on entering debug.
// R9 - With handshake on, every valid command during or after the low-power phase is acknowledged.
// R10 - Handshake is cleared only by system stop, and the host re-enables it with the enable command; the code also clears it on the disable command.
// R11 - The host starts every transfer with a falling edge on the debug wire.
// R12 - A low pulse longer than 128 cycles is a sync request.
// R13 - After a sync request the device waits for the rising edge with no time-out.
// R14 - A low pulse ending within 128 cycles is a bit, and the device waits for the next falling edge.
// R15 - No falling edge within 512 cycles of the last one soft-resets, dropping the command only.
// R16 - Without handshake, read data not collected within 512 cycles is dropped by a soft reset.
// R17 - A soft reset returns the receiver to idle with no partial command kept.
`timescale 1ns/1ps
`default_nettype none
module dwt_top
  import dwt_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        debug_wire_in,
  output logic             debug_wire_out,
  output logic             debug_wire_oe_out,
  input  wire logic        cpu_int_pending_in,
  input  wire logic        cpu_step_done_in,
  input  wire logic        cpu_step_low_power_in,
  input  wire logic        cpu_low_power_in,
  input  wire logic        system_stop_in,
  output logic             cpu_step_out,
  output logic             cpu_stack_only_out,
  output logic             debug_active_out,
  output logic             handshake_en_out,
  output logic             cmd_valid_out,
  output logic [7:0]       cmd_out,
  output logic             read_pending_out,
  output logic             sync_done_out,
  output logic             soft_reset_out
);
  dwt_rx_if rx ();

  dwt_step_t        step_st;
  logic [7:0]       shift;
  logic [4:0]       bit_cnt;
  logic             cmd_done;
  logic [7:0]       cmd_byte;
  logic             exec;
  logic             want_ack;
  logic             is_read;
  logic [4:0]       ack_cnt;
  logic             cmd_active;

  dwt_wire_timer dwt_wire_timer_inst (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .debug_wire_in (debug_wire_in),
    .rx            (rx.timer)
  );

  // The count is kept alive only while a command is part received or read data is owed;
  // with handshake on, read data waits as long as the host needs.
  assign cmd_active = (bit_cnt != 5'd0) || (read_pending_out && !handshake_en_out); // R16
  assign rx.arm     = cmd_active; // R15
  assign rx.ignore  = debug_wire_oe_out;

  // ---------------------------------------------------------------
  // Command byte assembly
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in || rx.timeout) begin
      shift    <= '0; // R17
      bit_cnt  <= '0;
      cmd_done <= 1'b0;
      cmd_byte <= '0;
    end else begin
      cmd_done <= 1'b0;
      if (rx.bit_valid && !read_pending_out) begin
        shift <= {shift[6:0], rx.bit_val};
        if (bit_cnt == 5'(CMD_BITS - 1)) begin
          bit_cnt  <= '0;
          cmd_done <= 1'b1;
          cmd_byte <= {shift[6:0], rx.bit_val};
        end else begin
          bit_cnt <= bit_cnt + 5'd1;
        end
      end
    end
  end

  // Enter-debug is held back while the CPU sleeps after a stepped stop or wait
  assign exec = cmd_done && !system_stop_in // R6
             && !(step_st == DWT_ST_LOWPWR && cmd_byte == CMD_ENTER_DEBUG); // R5
  assign is_read = cmd_byte[CMD_READ_BIT];

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cmd_valid_out <= 1'b0;
      cmd_out       <= '0;
    end else begin
      cmd_valid_out <= exec;
      if (exec) begin
        cmd_out <= cmd_byte;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read data window
  // ---------------------------------------------------------------
  logic [4:0] rd_cnt;
  always_ff @(posedge core_clk_in) begin
    if (rst_in || rx.timeout) begin
      read_pending_out <= 1'b0; // R16
      rd_cnt           <= '0;
    end else if (exec && is_read) begin
      read_pending_out <= 1'b1;
      rd_cnt           <= '0;
    end else if (read_pending_out && rx.bit_valid) begin
      if (rd_cnt == 5'(RD_BITS - 1)) begin
        read_pending_out <= 1'b0;
      end
      rd_cnt <= rd_cnt + 5'd1;
    end
  end

  // ---------------------------------------------------------------
  // Single-step sequencing
  // ---------------------------------------------------------------
  // Only the CPU is told to step; no freeze reaches the peripherals,
  // so stepped code loses its timing against them.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      step_st            <= DWT_ST_IDLE;
      cpu_step_out       <= 1'b0;
      cpu_stack_only_out <= 1'b0;
      debug_active_out   <= RST_ACTIVE;
    end else begin
      cpu_step_out <= 1'b0;
      unique case (step_st)
        DWT_ST_IDLE: begin
          if (exec && cmd_byte == CMD_STEP) begin
            cpu_step_out       <= 1'b1; // R2
            cpu_stack_only_out <= cpu_int_pending_in; // R1
            debug_active_out   <= 1'b0;
            step_st            <= DWT_ST_STEP;
          end else if (exec && cmd_byte == CMD_ENTER_DEBUG) begin
            debug_active_out <= 1'b1;
          end
        end
        DWT_ST_STEP: begin
          if (cpu_step_done_in) begin
            cpu_stack_only_out <= 1'b0;
            if (cpu_step_low_power_in) begin
              step_st <= DWT_ST_LOWPWR; // R4
            end else begin
              debug_active_out <= 1'b1;
              step_st          <= DWT_ST_IDLE;
            end
          end
        end
        DWT_ST_LOWPWR: begin
          if (!cpu_low_power_in) begin
            debug_active_out <= 1'b1; // R7
            step_st          <= DWT_ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Handshake and acknowledge drive
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      handshake_en_out <= RST_HANDSHAKE;
    end else if (system_stop_in) begin
      handshake_en_out <= 1'b0; // R10
    end else if (exec && cmd_byte == CMD_ACK_ENABLE) begin
      handshake_en_out <= 1'b1;
    end else if (exec && cmd_byte == CMD_ACK_DISABLE) begin
      handshake_en_out <= 1'b0;
    end
  end

  // A step owes its acknowledge at completion; one that ends in a sleep
  // never gets one, since debug entry on wake is not a command answer.
  assign want_ack = handshake_en_out
                 && ((exec && cmd_byte != CMD_STEP) // R9
                  || (step_st == DWT_ST_STEP && cpu_step_done_in && !cpu_step_low_power_in)); // R8

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ack_cnt           <= '0;
      debug_wire_oe_out <= 1'b0;
      debug_wire_out    <= 1'b1;
    end else begin
      if (want_ack && ack_cnt == 5'd0) begin
        ack_cnt           <= 5'(ACK_CYC);
        debug_wire_oe_out <= 1'b1;
        debug_wire_out    <= 1'b0;
      end else if (ack_cnt != 5'd0) begin
        ack_cnt <= ack_cnt - 5'd1;
        if (ack_cnt == 5'd1) begin
          debug_wire_oe_out <= 1'b0;
          debug_wire_out    <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync_done_out  <= 1'b0;
      soft_reset_out <= 1'b0;
    end else begin
      sync_done_out  <= rx.sync_done;
      soft_reset_out <= rx.timeout; // R15
    end
  end
endmodule
`default_nettype wire

// >>> hw/dwt_wire_timer.sv
// Debug wire pulse timer: bit, sync and idle time-out detection
`timescale 1ns/1ps
`default_nettype none
module dwt_wire_timer
  import dwt_pkg::*;
(
  input  wire logic   core_clk_in,
  input  wire logic   rst_in,
  input  wire logic   debug_wire_in,
  dwt_rx_if.timer     rx
);
  logic              wire_q;
  logic              in_low;
  logic              in_sync;
  logic [LOW_W-1:0]  low_cnt;
  logic [IDLE_W-1:0] idle_cnt;
  logic              fall;
  logic              rise;

  // Own acknowledge drive must not be read back as host traffic
  assign fall = wire_q && !debug_wire_in && !rx.ignore;
  assign rise = !wire_q && debug_wire_in && in_low;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wire_q <= 1'b1;
    end else begin
      wire_q <= debug_wire_in;
    end
  end

  // ---------------------------------------------------------------
  // Low phase measurement
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      in_low  <= 1'b0;
      in_sync <= 1'b0;
      low_cnt <= '0;
    end else if (fall) begin
      in_low  <= 1'b1;
      in_sync <= 1'b0;
      low_cnt <= '0;
    end else if (rise) begin
      in_low  <= 1'b0;
      in_sync <= 1'b0;
    end else if (in_low) begin
      // The low sample after the 128th makes the pulse a sync; 128 low samples is still a bit
      if (low_cnt != LOW_W'(SYNC_CYC - 1)) begin
        low_cnt <= low_cnt + LOW_W'(1);
      end else begin
        in_sync <= 1'b1; // R12
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx.bit_valid <= 1'b0;
      rx.bit_val   <= 1'b0;
      rx.sync_done <= 1'b0;
    end else begin
      // Answer a sync only at its rising edge, however long it takes
      rx.sync_done <= rise && in_sync; // R13
      rx.bit_valid <= rise && !in_sync; // R14
      if (rise && !in_sync) begin
        rx.bit_val <= (low_cnt < LOW_W'(BIT1_CYC));
      end
    end
  end

  // ---------------------------------------------------------------
  // Gap between falling edges
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      idle_cnt   <= '0;
      rx.timeout <= 1'b0;
    end else begin
      rx.timeout <= 1'b0;
      if (fall || !rx.arm || in_sync) begin
        idle_cnt <= '0; // R13
      end else if (idle_cnt == IDLE_W'(IDLE_CYC - 1)) begin
        idle_cnt   <= '0;
        rx.timeout <= 1'b1; // R15
      end else begin
        idle_cnt <= idle_cnt + IDLE_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/dwt_host_model.sv
// Host debugger pod model that pulls the debug wire low in timed pulses
`timescale 1ns/1ps
`default_nettype none
module dwt_host_model (
  input  wire logic core_clk_in,
  output var  logic host_low_out
);
  // ------------------------------
  // Pulse generation
  // ------------------------------
  initial host_low_out = 1'b0;

  // The wire is only pulled low or released, so the pull-up sets the idle level
  task automatic pulse(input int lo, input int hi);
    @(posedge core_clk_in);
    host_low_out <= 1'b1;
    repeat (lo) @(posedge core_clk_in);
    host_low_out <= 1'b0;
    repeat (hi) @(posedge core_clk_in);
  endtask

  // Sends MSB first; only command bytes go out, never a step over a breakpoint
  task automatic send(input logic [7:0] b, input logic [31:0] r);
    for (int i = 7; i >= 0; i--) pulse(b[i] ? 2 + int'(r[5:4]) : 20 + int'(r[11:6]), 3 + int'(r[3:0]));
  endtask
endmodule
`default_nettype wire

// >>> testbench/dwt_top_assertions.sv
// Port-level assertions for the debug wire trace and time-out block
`timescale 1ns/1ps
`default_nettype none
module dwt_top_assertions
  import dwt_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  input wire logic       debug_wire_in,
  input wire logic       debug_wire_out,
  input wire logic       debug_wire_oe_out,
  input wire logic       cpu_int_pending_in,
  input wire logic       cpu_step_done_in,
  input wire logic       cpu_step_low_power_in,
  input wire logic       cpu_low_power_in,
  input wire logic       system_stop_in,
  input wire logic       cpu_step_out,
  input wire logic       cpu_stack_only_out,
  input wire logic       debug_active_out,
  input wire logic       handshake_en_out,
  input wire logic       cmd_valid_out,
  input wire logic [7:0] cmd_out,
  input wire logic       read_pending_out,
  input wire logic       sync_done_out,
  input wire logic       soft_reset_out
);
  // ------------------------------
  // Helper counters
  // ------------------------------
  logic [7:0] lowc;
  logic [9:0] gap;
  logic [4:0] ackc;
  logic       wire_q;

  always_ff @(posedge core_clk_in) begin
    if (rst_in || debug_wire_in) lowc <= 8'h00;
    else if (lowc != 8'hff) lowc <= lowc + 8'h01;
  end

  // Falls made by our own acknowledge do not restart the gap
  always_ff @(posedge core_clk_in) begin
    wire_q <= rst_in | debug_wire_in;
    if (rst_in || (wire_q && !debug_wire_in && !debug_wire_oe_out)) gap <= 10'h000;
    else if (gap != 10'h3ff) gap <= gap + 10'h001;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in || !debug_wire_oe_out) ackc <= 5'h00;
    else ackc <= ackc + 5'h01;
  end

  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_sync_len: assert property (sync_done_out |-> debug_wire_in && $past(lowc, 3) >= 8'd128)
    else $error("sync answered after a short pulse");
  a_idle_gap: assert property (soft_reset_out |-> gap >= 10'd505)
    else $error("soft reset before the idle limit");
  a_ack_len: assert property ($fell(debug_wire_oe_out) |-> ackc == ACK_CYC)
    else $error("acknowledge pulse has wrong length");
  a_ack_drive: assert property (debug_wire_oe_out |-> !debug_wire_out)
    else $error("driven wire is not low");
  a_idle_release: assert property (!debug_wire_oe_out |-> debug_wire_out)
    else $error("released wire output not high");
  a_step_source: assert property (cpu_step_out |-> cmd_valid_out && cmd_out == CMD_STEP)
    else $error("step without a step command");
  a_stack_int: assert property (cpu_step_out && cpu_int_pending_in |-> ##[0:1] cpu_stack_only_out)
    else $error("pending interrupt not stacked");
  a_step_entry: assert property (cpu_step_done_in && !cpu_step_low_power_in |=> debug_active_out)
    else $error("no debug entry after step");
  a_wake_entry: assert property ($rose(debug_active_out) |-> !$past(cpu_low_power_in))
    else $error("debug entered while cpu asleep");
  a_stop_mute: assert property (system_stop_in && $past(system_stop_in) |-> !cmd_valid_out && !cpu_step_out)
    else $error("command executed in system stop");
  a_stop_clear: assert property (system_stop_in |=> !handshake_en_out)
    else $error("handshake kept in system stop");

  c_sync: cover property (sync_done_out);
  c_soft: cover property (soft_reset_out);
  c_stack: cover property (cpu_stack_only_out);
  c_ack: cover property (handshake_en_out && debug_wire_oe_out);
endmodule
bind dwt_top dwt_top_assertions dwt_top_assertions_inst (.*);
`default_nettype wire

// >>> testbench/test_debug_wire_trace_timeout.sv
// Self-checking bench for the debug wire trace and time-out block
`timescale 1ns/1ps
`default_nettype none
module test_debug_wire_trace_timeout;
  import dwt_pkg::*;
  logic        clk, rst, host_low, wire_lv, int_p, s_done, s_lp, lp, sys_stop, oe_q;
  logic        wire_o, oe, step, stack, active, hs, cvalid, rdp, syncd, sreset;
  logic [7:0]  cmd;
  logic [8:0]  exp_q[$];
  logic [31:0] r;
  int          n_errors = 0;
  int          n_compared = 0;
  int          n_ack = 0;
  int          n_step = 0;

  // ------------------------------
  // Wire, clock and instances
  // ------------------------------
  assign wire_lv = !host_low && !(oe && !wire_o);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  dwt_top dwt_top_inst (.core_clk_in(clk), .rst_in(rst), .debug_wire_in(wire_lv), .debug_wire_out(wire_o),
    .debug_wire_oe_out(oe), .cpu_int_pending_in(int_p), .cpu_step_done_in(s_done), .cpu_step_low_power_in(s_lp),
    .cpu_low_power_in(lp), .system_stop_in(sys_stop), .cpu_step_out(step), .cpu_stack_only_out(stack),
    .debug_active_out(active), .handshake_en_out(hs), .cmd_valid_out(cvalid), .cmd_out(cmd),
    .read_pending_out(rdp), .sync_done_out(syncd), .soft_reset_out(sreset));
  dwt_host_model dwt_host_model_inst (.core_clk_in(clk), .host_low_out(host_low));

  // ------------------------------
  // Tasks
  // ------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic fail(input string m);
    n_errors++;
    $display("ERROR %0t %s", $time, m);
  endtask

  task automatic chk_ev(input logic [8:0] got);
    n_compared++;
    if (exp_q.size() == 0) fail("unexpected event");
    else if (exp_q.pop_front() !== got) fail("event mismatch");
  endtask

  task automatic chk_lv(input logic got, input logic e);
    n_compared++;
    if (got !== e) fail("level mismatch");
  endtask

  task automatic finish_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic tx(input logic [7:0] b, input logic e);
    r = xs(r);
    if (e) exp_q.push_back({1'b0, b});
    dwt_host_model_inst.send(b, r);
    repeat (40) @(posedge clk);
  endtask

  task automatic done(input logic l);
    @(posedge clk);
    s_done <= 1'b1;
    s_lp   <= l;
    @(posedge clk);
    s_done <= 1'b0;
  endtask

  // ------------------------------
  // Result watcher
  // ------------------------------
  always @(posedge clk) begin
    oe_q <= oe;
    if (oe && !oe_q) n_ack <= n_ack + 1;
    if (!rst && step) n_step <= n_step + 1;
    if (!rst && cvalid) chk_ev({1'b0, cmd});
    if (!rst && syncd) chk_ev(9'h100);
    if (!rst && sreset) chk_ev(9'h1ff);
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail("watchdog expired");
    finish_test();
  end

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {rst, int_p, s_done, s_lp, lp, sys_stop} = 6'h20;
    r = 32'h9b4f368d;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tx(CMD_ACK_ENABLE, 1'b1);
    chk_lv(hs, 1'b1);
    // Handshake is still off in the cycle the enable executes, so no acknowledge yet
    chk_lv(n_ack == 0, 1'b1);
    int_p <= 1'b1;
    tx(CMD_STEP, 1'b1);
    chk_lv(stack, 1'b1);
    chk_lv(n_step == 1, 1'b1);
    done(1'b0);
    @(posedge clk);
    chk_lv(active, 1'b1);
    chk_lv(stack, 1'b0);
    repeat (30) @(posedge clk);
    chk_lv(n_ack == 1, 1'b1);
    int_p <= 1'b0;
    tx(CMD_STEP, 1'b1);
    chk_lv(n_step == 2, 1'b1);
    lp <= 1'b1;
    done(1'b1);
    repeat (30) @(posedge clk);
    chk_lv(active, 1'b0);
    tx(CMD_ACK_ENABLE, 1'b1);
    chk_lv(n_ack == 2, 1'b1);
    // Enter-debug is held back while asleep: no execution, no acknowledge
    tx(CMD_ENTER_DEBUG, 1'b0);
    chk_lv(active, 1'b0);
    lp <= 1'b0;
    repeat (30) @(posedge clk);
    chk_lv(active, 1'b1);
    chk_lv(n_ack == 2, 1'b1);
    // A bit, syncs of 129 and 700 low cycles inside the open command, then a 128-cycle bit and two short bits left unfinished
    dwt_host_model_inst.pulse(3, 5);
    exp_q.push_back(9'h100);
    dwt_host_model_inst.pulse(129, 60);
    exp_q.push_back(9'h100);
    dwt_host_model_inst.pulse(700, 60);
    exp_q.push_back(9'h1ff);
    dwt_host_model_inst.pulse(128, 5);
    dwt_host_model_inst.pulse(3, 5);
    dwt_host_model_inst.pulse(3, 600);
    tx(CMD_ACK_DISABLE, 1'b1);
    chk_lv(hs, 1'b0);
    tx(8'he4, 1'b1);
    exp_q.push_back(9'h1ff);
    chk_lv(rdp, 1'b1);
    repeat (520) @(posedge clk);
    chk_lv(rdp, 1'b0);
    tx(CMD_ACK_ENABLE, 1'b1);
    sys_stop <= 1'b1;
    repeat (3) @(posedge clk);
    chk_lv(hs, 1'b0);
    tx(CMD_ACK_ENABLE, 1'b0);
    sys_stop <= 1'b0;
    repeat (5) @(posedge clk);
    chk_lv(hs, 1'b0);
    tx(CMD_ACK_ENABLE, 1'b1);
    chk_lv(hs, 1'b1);
    chk_lv(exp_q.size() == 0, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
